//--- rtl/acj_exec_regs.vh
// Behaviour
// RULE1: opcode 82: carry becomes carry AND bit
// RULE2: opcode b0: carry becomes carry AND NOT bit
// RULE3: inverted bit operand never written back
// RULE4: opcode 53: direct byte ANDed with immediate
// RULE5: opcode 52: direct byte ANDed with accumulator
// RULE6: direct and bit addresses are one byte
// RULE7: opcodes b6/b7: compare immediate with @working register; code uses @working register as first operand
// RULE8: opcode b4: compare accumulator with immediate
// RULE9: opcode b5: compare accumulator with direct byte
// RULE10: pc plus three, plus offset if unequal
// RULE11: equal operands: fall through, no offset
// RULE12: carry set when first operand below second
// RULE13: compare bytes: opcode, operand, offset
// RULE14: offset signed, compared operands unsigned
`ifndef ACJ_EXEC_REGS_VH
`define ACJ_EXEC_REGS_VH
`define ACJ_OP_AND_BIT 8'h82
`define ACJ_OP_AND_NBIT 8'hb0
`define ACJ_OP_AND_DIR_IMM 8'h53
`define ACJ_OP_AND_DIR_ACC 8'h52
`define ACJ_OP_CMPJ_IND 7'h5b
`define ACJ_OP_CMPJ_IMM 8'hb4
`define ACJ_OP_CMPJ_DIR 8'hb5
`define ACJ_PC_RESET 16'h0000
`define ACJ_CARRY_RESET 1'b0
`endif

//--- rtl/acj_exec.v
`timescale 1ns/1ps
`include "acj_exec_regs.vh"
module acj_exec #(
  parameter ADDR_W = 8,
  parameter PC_W = 16
) (
  input wire clk,
  input wire rst,
  input wire [7:0] codeByte,
  input wire codeValid,
  output reg codeReady_q,
  input wire [7:0] accIn,
  input wire [7:0] reg0In,
  input wire [7:0] reg1In,
  input wire pcLoad,
  input wire [PC_W-1:0] pcLoadValue,
  input wire carryLoad,
  input wire carryIn,
  output reg [ADDR_W-1:0] memAddr_q,
  output reg memRd_q,
  input wire [7:0] memRdData,
  output reg memWr_q,
  output reg [7:0] memWrData_q,
  output reg [ADDR_W-1:0] bitAddr_q,
  output reg bitRd_q,
  input wire bitRdData,
  output reg [PC_W-1:0] pc_q,
  output reg carry_q,
  output reg done_q,
  output reg illegal_q
);

  localparam [4:0] S_OPC = 5'b00001;
  localparam [4:0] S_ARG1 = 5'b00010;
  localparam [4:0] S_ARG2 = 5'b00100;
  localparam [4:0] S_RDW = 5'b01000;
  localparam [4:0] S_EXEC = 5'b10000;

  // opcode is one this block executes
  function known;
    input [7:0] op;
    begin
      known = (op == `ACJ_OP_AND_BIT) || (op == `ACJ_OP_AND_NBIT) ||
              (op == `ACJ_OP_AND_DIR_IMM) || (op == `ACJ_OP_AND_DIR_ACC) ||
              (op[7:1] == `ACJ_OP_CMPJ_IND) || (op == `ACJ_OP_CMPJ_IMM) ||
              (op == `ACJ_OP_CMPJ_DIR);
    end
  endfunction

  // three-byte compare forms
  function isCmp;
    input [7:0] op;
    begin
      isCmp = (op[7:1] == `ACJ_OP_CMPJ_IND) || (op == `ACJ_OP_CMPJ_IMM) || (op == `ACJ_OP_CMPJ_DIR);
    end
  endfunction

  reg [4:0] state_q, state_d;
  reg [7:0] op_q, op_d;
  reg [7:0] arg1_q, arg1_d;
  reg [7:0] arg2_q, arg2_d;
  reg codeReady_d;
  reg [ADDR_W-1:0] memAddr_d;
  reg memRd_d;
  reg memWr_d;
  reg [7:0] memWrData_d;
  reg [ADDR_W-1:0] bitAddr_d;
  reg bitRd_d;
  reg [PC_W-1:0] pc_d;
  reg carry_d;
  reg done_d;
  reg illegal_d;
  reg [7:0] cmpA;
  reg [7:0] cmpB;

  wire take = codeValid & codeReady_q;
  wire [PC_W-1:0] pcInc = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  // offset sign-extended to pc width
  wire [PC_W-1:0] offsetExt = {{(PC_W-8){arg2_q[7]}}, arg2_q}; // RULE14
  wire [7:0] indPtr = op_q[0] ? reg1In : reg0In; // RULE7

  always @* begin
    state_d = state_q;
    op_d = op_q;
    arg1_d = arg1_q;
    arg2_d = arg2_q;
    memAddr_d = memAddr_q;
    memRd_d = 1'b0;
    memWr_d = 1'b0;
    memWrData_d = memWrData_q;
    bitAddr_d = bitAddr_q;
    bitRd_d = 1'b0;
    pc_d = pc_q;
    carry_d = carry_q;
    done_d = 1'b0;
    illegal_d = 1'b0;
    cmpA = 8'h00;
    cmpB = 8'h00;
    case (state_q)
      S_OPC: begin
        if (take) begin
          op_d = codeByte;
          pc_d = pcInc;
          if (known(codeByte)) begin
            state_d = S_ARG1;
          end else begin
            illegal_d = 1'b1;
          end
        end
      end
      S_ARG1: begin
        if (take) begin
          arg1_d = codeByte;
          pc_d = pcInc;
          if (op_q == `ACJ_OP_AND_BIT || op_q == `ACJ_OP_AND_NBIT) begin
            bitAddr_d = codeByte; // RULE6
            bitRd_d = 1'b1;
            state_d = S_RDW;
          end else if (op_q == `ACJ_OP_AND_DIR_ACC) begin
            memAddr_d = codeByte; // RULE6
            memRd_d = 1'b1;
            state_d = S_RDW;
          end else begin
            state_d = S_ARG2; // RULE13
          end
        end
      end
      S_ARG2: begin
        if (take) begin
          arg2_d = codeByte;
          pc_d = pcInc; // RULE10
          if (op_q == `ACJ_OP_CMPJ_IMM) begin
            state_d = S_EXEC;
          end else begin
            memAddr_d = (op_q[7:1] == `ACJ_OP_CMPJ_IND) ? indPtr : arg1_q; // RULE7
            memRd_d = 1'b1;
            state_d = S_RDW;
          end
        end
      end
      S_RDW: begin
        state_d = S_EXEC;
      end
      S_EXEC: begin
        state_d = S_OPC;
        done_d = 1'b1;
        if (op_q == `ACJ_OP_AND_BIT) begin
          carry_d = carry_q & bitRdData; // RULE1
        end else if (op_q == `ACJ_OP_AND_NBIT) begin
          // no bit write port exists, so the source bit stays as it was
          carry_d = carry_q & ~bitRdData; // RULE2 RULE3
        end else if (op_q == `ACJ_OP_AND_DIR_IMM) begin
          memWr_d = 1'b1;
          memWrData_d = memRdData & arg2_q; // RULE4
        end else if (op_q == `ACJ_OP_AND_DIR_ACC) begin
          memWr_d = 1'b1;
          memWrData_d = memRdData & accIn; // RULE5
        end else if (isCmp(op_q)) begin
          if (op_q == `ACJ_OP_CMPJ_IMM) begin
            cmpA = accIn; // RULE8
            cmpB = arg1_q;
          end else if (op_q == `ACJ_OP_CMPJ_DIR) begin
            cmpA = accIn; // RULE9
            cmpB = memRdData;
          end else begin
            cmpA = memRdData; // RULE7
            cmpB = arg1_q;
          end
          carry_d = (cmpA < cmpB); // RULE12 RULE14
          if (cmpA != cmpB) begin
            pc_d = pc_q + offsetExt; // RULE10
          end // RULE11
        end
      end
      default: begin
        state_d = S_OPC;
      end
    endcase
    if (pcLoad) begin
      pc_d = pcLoadValue;
    end
    if (carryLoad) begin
      carry_d = carryIn;
    end
    codeReady_d = (state_d == S_OPC) || (state_d == S_ARG1) || (state_d == S_ARG2);
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_OPC;
      op_q <= 8'h00;
      arg1_q <= 8'h00;
      arg2_q <= 8'h00;
      codeReady_q <= 1'b0;
      memAddr_q <= {ADDR_W{1'b0}};
      memRd_q <= 1'b0;
      memWr_q <= 1'b0;
      memWrData_q <= 8'h00;
      bitAddr_q <= {ADDR_W{1'b0}};
      bitRd_q <= 1'b0;
      pc_q <= `ACJ_PC_RESET;
      carry_q <= `ACJ_CARRY_RESET;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      arg1_q <= arg1_d;
      arg2_q <= arg2_d;
      codeReady_q <= codeReady_d;
      memAddr_q <= memAddr_d;
      memRd_q <= memRd_d;
      memWr_q <= memWr_d;
      memWrData_q <= memWrData_d;
      bitAddr_q <= bitAddr_d;
      bitRd_q <= bitRd_d;
      pc_q <= pc_d;
      carry_q <= carry_d;
      done_q <= done_d;
      illegal_q <= illegal_d;
    end
  end

endmodule // acj_exec

//--- dv/acj_mem_model.sv
`timescale 1ns/1ps
module acj_mem_model (
  input wire clk,
  input wire [7:0] memAddr_q,
  input wire memRd_q,
  input wire memWr_q,
  input wire [7:0] memWrData_q,
  input wire [7:0] bitAddr_q,
  input wire bitRd_q,
  output reg [7:0] memRdData = 8'h00,
  output reg bitRdData = 1'b0
);
  reg [7:0] mem [0:255];
  reg bits [0:255];
  // idle read lines toggle so stale data is never reused
  always @(posedge clk) begin
    memRdData <= memRd_q ? mem[memAddr_q] : ~memRdData;
    bitRdData <= bitRd_q ? bits[bitAddr_q] : ~bitRdData;
    if (memWr_q) mem[memAddr_q] <= memWrData_q;
  end
endmodule // acj_mem_model

//--- dv/acj_exec_checker.sv
`timescale 1ns/1ps
module acj_exec_checker #(parameter ADDR_W = 8, parameter PC_W = 16) (
  input wire clk,
  input wire rst,
  input wire codeValid,
  input wire codeReady_q,
  input wire pcLoad,
  input wire carryLoad,
  input wire [ADDR_W-1:0] memAddr_q,
  input wire memRd_q,
  input wire memWr_q,
  input wire bitRd_q,
  input wire [PC_W-1:0] pc_q,
  input wire carry_q,
  input wire done_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  bit_done_a: assert property (bitRd_q |-> ##2 done_q) else $error("bit late");
  bit_keep_a: assert property (bitRd_q |-> !memWr_q [*3]) else $error("bit write");
  wr_done_a: assert property (memWr_q |-> done_q) else $error("wr done");
  rd_wr_a: assert property (memWr_q |-> $past(memRd_q, 2)) else $error("wr no rd");
  addr_keep_a: assert property (memWr_q |-> memAddr_q == $past(memAddr_q, 2)) else $error("addr");
  done_rdy_a: assert property (done_q |-> codeReady_q) else $error("rdy");
  pc_step_a: assert property (codeValid && codeReady_q && !pcLoad |=> pc_q == $past(pc_q) + 1'b1)
    else $error("pc step");
  carry_hold_a: assert property ($changed(carry_q) && !$past(carryLoad) |-> done_q) else $error("c");
endmodule // acj_exec_checker
bind acj_exec acj_exec_checker #(.ADDR_W(ADDR_W), .PC_W(PC_W)) u_chk (.clk, .rst, .codeValid, .codeReady_q,
  .pcLoad, .carryLoad, .memAddr_q, .memRd_q, .memWr_q, .bitRd_q, .pc_q, .carry_q, .done_q);

//--- dv/test_and_bit_and_compare_jump_exec.sv
`timescale 1ns/1ps
module test_and_bit_and_compare_jump_exec;
  reg clk = 1'b0, rst = 1'b1, codeValid = 1'b0, pcLoad = 1'b0, carryLoad = 1'b0, carryIn = 1'b0;
  reg [7:0] codeByte = 8'h00, accIn = 8'h00, reg0In = 8'h00, reg1In = 8'h00;
  reg [15:0] pcLoadValue = 16'h0000;
  wire [7:0] memAddr_q, memWrData_q, bitAddr_q, memRdData;
  wire codeReady_q, memRd_q, memWr_q, bitRd_q, bitRdData, carry_q, done_q, illegal_q;
  wire [15:0] pc_q;
  integer fails = 0, checks_done = 0, cyc = 0;
  always #5 clk = ~clk;
  acj_exec u_dut (.clk, .rst, .codeByte, .codeValid, .codeReady_q, .accIn, .reg0In, .reg1In, .pcLoad,
    .pcLoadValue, .carryLoad, .carryIn, .memAddr_q, .memRd_q, .memRdData, .memWr_q, .memWrData_q,
    .bitAddr_q, .bitRd_q, .bitRdData, .pc_q, .carry_q, .done_q, .illegal_q);
  acj_mem_model u_mem (.clk, .memAddr_q, .memRd_q, .memWr_q, .memWrData_q, .bitAddr_q, .bitRd_q,
    .memRdData, .bitRdData);
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 2000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  task chk(input string n, input [15:0] s, input [15:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("MISMATCH %0s exp %h seen %h", n, e, s);
    end
  endtask
  // load pc and carry, then send n bytes and wait for done
  task op(input [7:0] a, b, c, input integer n, input [15:0] p, input ci);
    integer i;
    begin
      @(posedge clk);
      pcLoad <= 1'b1;
      pcLoadValue <= p;
      carryLoad <= 1'b1;
      carryIn <= ci;
      @(posedge clk);
      pcLoad <= 1'b0;
      carryLoad <= 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        codeByte <= i == 0 ? a : i == 1 ? b : c;
        codeValid <= 1'b1;
        @(posedge clk);
        while (codeReady_q !== 1'b1) @(posedge clk);
      end
      codeValid <= 1'b0;
      // sample settled outputs just after the edge
      repeat (9) if (done_q !== 1'b1) begin
        @(posedge clk);
        #1;
      end
      chk("done", done_q, 1'b1);
      @(posedge clk);
      #1;
    end
  endtask
  task t_ill;
    @(posedge clk);
    pcLoad <= 1'b1;
    pcLoadValue <= 16'h2000;
    @(posedge clk);
    pcLoad <= 1'b0;
    codeByte <= 8'h00;
    codeValid <= 1'b1;
    @(posedge clk);
    codeValid <= 1'b0;
    #1;
    chk("illegal", illegal_q, 1'b1);
    chk("pc", pc_q, 16'h2001);
    chk("done", done_q, 1'b0);
    @(posedge clk);
    #1;
    chk("illegal", illegal_q, 1'b0);
    chk("ready", codeReady_q, 1'b1);
    $display("illegal test done");
  endtask
  task t_bit;
    u_mem.bits[8'h45] = 1'b1;
    op(8'h82, 8'h45, 8'h00, 2, 16'h0000, 1'b1);
    chk("carry", carry_q, 1'b1);
    chk("pc", pc_q, 16'h0002);
    op(8'hb0, 8'h45, 8'h00, 2, 16'h0000, 1'b1);
    chk("carry", carry_q, 1'b0);
    chk("bit", u_mem.bits[8'h45], 1'b1);
    $display("bit test done");
  endtask
  task t_mem;
    u_mem.mem[8'hff] = 8'h77;
    u_mem.mem[8'h10] = 8'h31;
    accIn <= 8'h81;
    op(8'h53, 8'hff, 8'h01, 3, 16'h0000, 1'b0);
    chk("mem", u_mem.mem[8'hff], 8'h01);
    op(8'h52, 8'h10, 8'h00, 2, 16'h0000, 1'b0);
    chk("mem", u_mem.mem[8'h10], 8'h01);
    $display("memory test done");
  endtask
  task cj(input [7:0] o, x, f, input [15:0] p, input c);
    op(o, x, f, 3, 16'h10dc, 1'b1);
    chk("pc", pc_q, p);
    chk("carry", carry_q, c);
  endtask
  task t_cmp;
    accIn <= 8'h50;
    reg0In <= 8'h20;
    reg1In <= 8'h53;
    u_mem.mem[8'h20] = 8'h05;
    u_mem.mem[8'h53] = 8'he1;
    u_mem.mem[8'h37] = 8'h50;
    cj(8'hb4, 8'h10, 8'h56, 16'h1135, 1'b0);
    cj(8'hb7, 8'h01, 8'hfd, 16'h10dc, 1'b0);
    cj(8'hb6, 8'h06, 8'h80, 16'h105f, 1'b1);
    cj(8'hb5, 8'h37, 8'h4c, 16'h10df, 1'b0);
    $display("compare test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_bit;
    t_mem;
    t_cmp;
    t_ill;
    end_sim;
  end
endmodule // test_and_bit_and_compare_jump_exec
